/* sa_arbiter.sv */
// storage unit and display memory access arbiter
`timescale 1ns/100ps
`default_nettype none
module sa_arbiter #(
  parameter int NCE = 3,
  parameter int NIO = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // storage unit requests
  input wire logic [NCE-1:0] su_ce_req_i,
  input wire logic [NCE-1:0] su_ce_par_i,
  input wire logic [NIO-1:0] su_io_req_i,
  input wire logic [NIO-1:0] su_io_store_i,
  input wire logic [NIO-1:0] su_io_par_i,
  output logic [NCE-1:0] su_ce_gnt_o,
  output logic [NIO-1:0] su_io_gnt_o,
  output logic [1:0] su_busy_o,
  // display memory requests
  input wire logic [NCE-1:0] dm_ce_req_i,
  input wire logic [NCE-1:0] dm_ce_par_i,
  input wire logic [sa_pkg::DM_QW_SLOTS-1:0] dg_req_i,
  input wire logic [sa_pkg::DM_QW_SLOTS-1:0] dg_par_i,
  output logic [NCE-1:0] dm_ce_gnt_o,
  output logic [sa_pkg::DM_QW_SLOTS-1:0] dg_gnt_o,
  output logic dm_start_o,
  output logic dm_dg_o,
  output logic dm_bank_o
);
  import sa_pkg::*;
  localparam logic [CNT_W-1:0] SU_LOAD = CNT_W'(SU_CYC_CLKS - 1);
  localparam logic [CNT_W-1:0] DM_LOAD = CNT_W'(DM_CYC_CLKS - 1);
  localparam int FRAME_CLKS = 9 * DM_CYC_CLKS;
  localparam int SU_HOLD_PAST = IO_HOLD_CLKS - 1;

  function automatic logic [NIO-1:0] lowest_one(input logic [NIO-1:0] v);
    return v & (~v + NIO'(1));
  endfunction

  ////////////////////////////////////////////////////////////////////
  // storage unit: store hold-off shared by both banks

  logic [NIO-1:0] store_ok;
  logic [NIO-1:0] su_io_gnt_b [2];
  logic [NCE-1:0] su_ce_gnt_b [2];

  sa_store_hold #(
    .N(NIO),
    .HOLD(IO_HOLD_CLKS)
  ) u_hold (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .req_i(su_io_req_i),
    .store_i(su_io_store_i),
    .ok_o(store_ok)
  );

  ////////////////////////////////////////////////////////////////////
  // storage unit: one independent arbiter per doubleword parity

  for (genvar b = 0; b < 2; b++)
  begin : g_su
    logic [NIO-1:0] io_mine;
    logic [NIO-1:0] io_elig;
    logic [NCE-1:0] ce_mine;
    logic [CNT_W-1:0] busy_r;
    logic [CNT_W-1:0] busy_nxt;
    logic free;
    logic ce_take;
    logic any_gnt;

    always_comb
    begin
      io_mine = su_io_req_i & ((b == 1) ? su_io_par_i : ~su_io_par_i);
      ce_mine = su_ce_req_i & ((b == 1) ? su_ce_par_i : ~su_ce_par_i);
      io_elig = io_mine & ~(su_io_store_i & ~store_ok);
      free = (busy_r == '0);
      su_io_gnt_b[b] = free ? lowest_one(io_elig) : '0;
      ce_take = free && (io_elig == '0);
      any_gnt = (su_io_gnt_b[b] != '0) || (su_ce_gnt_b[b] != '0);
      if (any_gnt)
        busy_nxt = SU_LOAD;
      else if (!free)
        busy_nxt = busy_r - CNT_W'(1);
      else
        busy_nxt = busy_r;
    end

    always_ff @(posedge clk_i)
    begin
      if (!rst_b_i)
        busy_r <= '0;
      else
        busy_r <= busy_nxt;
    end

    sa_ce_rotor #(
      .N(NCE)
    ) u_rot (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .req_i(ce_mine),
      .take_i(ce_take),
      .gnt_o(su_ce_gnt_b[b])
    );

    assign su_busy_o[b] = !free;

    one_grant_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $onehot0({su_io_gnt_b[b], su_ce_gnt_b[b]}))
      else $error("more than one grant in a storage cycle");

    io_over_ce_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (io_elig != '0) |-> (su_ce_gnt_b[b] == '0))
      else $error("computing element granted over eligible io element");

    cycle_span_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      any_gnt |=> (!any_gnt && !free) [*8])
      else $error("storage bank regranted inside its cycle");

    fetch_now_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (free && (io_mine & ~su_io_store_i) != '0) |-> (su_io_gnt_b[b] != '0))
      else $error("io fetch not granted on a free bank");

    use_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (free && io_elig == '0 && ce_mine != '0) |-> (su_ce_gnt_b[b] != '0))
      else $error("free cycle left idle while computing element waits");
  end

  always_comb
  begin
    su_io_gnt_o = su_io_gnt_b[0] | su_io_gnt_b[1];
    su_ce_gnt_o = su_ce_gnt_b[0] | su_ce_gnt_b[1];
  end

  for (genvar i = 0; i < NIO; i++)
  begin : g_chk
    store_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (su_io_gnt_o[i] && su_io_store_i[i])
        |-> $past(su_io_req_i[i] && su_io_store_i[i], SU_HOLD_PAST))
      else $error("io store granted before its hold-off");
  end

  ////////////////////////////////////////////////////////////////////
  // display memory: free running nine-cycle frame

  logic [CNT_W-1:0] dm_cnt_r;
  logic [CNT_W-1:0] dm_cnt_nxt;
  sa_dm_phase_e dm_phase_r;
  sa_dm_phase_e dm_phase_nxt;
  logic [DM_SLOT_W-1:0] dm_slot_r;
  logic [DM_SLOT_W-1:0] dm_slot_nxt;
  logic dm_take_r;
  logic dm_take_nxt;
  logic dm_par_r;
  logic dm_par_nxt;
  logic dm_dg_r;
  logic dm_dg_nxt;
  logic dm_bank_r;
  logic dm_bank_nxt;
  logic dm_start;
  logic dm_ce_cycle;
  logic dm_pref;
  logic dm_use_odd;
  logic [NCE-1:0] dm_ce_even;
  logic [NCE-1:0] dm_ce_odd;
  logic [NCE-1:0] dm_gnt_even;
  logic [NCE-1:0] dm_gnt_odd;

  always_comb
  begin
    dm_start = (dm_cnt_r == '0);
    dm_cnt_nxt = dm_start ? DM_LOAD : dm_cnt_r - CNT_W'(1);
    dm_phase_nxt = dm_phase_r;
    dm_slot_nxt = dm_slot_r;
    dm_take_nxt = dm_take_r;
    dm_par_nxt = dm_par_r;
    dm_dg_nxt = dm_dg_r;
    dm_bank_nxt = dm_bank_r;
    dg_gnt_o = '0;
    dm_ce_cycle = 1'b0;
    if (dm_start)
    begin
      case (dm_phase_r)
        DM_FIRST:
        begin
          // slot owner decides at the start of its quadword
          dm_take_nxt = dg_req_i[dm_slot_r];
          dm_par_nxt = dg_par_i[dm_slot_r];
          dg_gnt_o[dm_slot_r] = dg_req_i[dm_slot_r];
          dm_ce_cycle = !dg_req_i[dm_slot_r];
          dm_phase_nxt = DM_SECOND;
        end
        DM_SECOND:
        begin
          dm_ce_cycle = !dm_take_r;
          if (dm_slot_r == DM_LAST_SLOT)
          begin
            dm_phase_nxt = DM_RESV;
          end
          else
          begin
            dm_phase_nxt = DM_FIRST;
            dm_slot_nxt = dm_slot_r + DM_SLOT_W'(1);
          end
        end
        DM_RESV:
        begin
          dm_ce_cycle = 1'b1;
          dm_take_nxt = 1'b0;
          dm_phase_nxt = DM_FIRST;
          dm_slot_nxt = DM_FIRST_SLOT;
        end
        default:
        begin
          dm_phase_nxt = DM_FIRST;
          dm_slot_nxt = DM_FIRST_SLOT;
        end
      endcase
    end
    // only computing elements and display generators reach this memory
    dm_ce_even = dm_ce_req_i & ~dm_ce_par_i;
    dm_ce_odd = dm_ce_req_i & dm_ce_par_i;
    dm_pref = (dm_phase_r == DM_SECOND) ? ODD_BANK : EVEN_BANK;
    if (dm_pref == ODD_BANK)
      dm_use_odd = (dm_ce_odd != '0) || (dm_ce_even == '0);
    else
      dm_use_odd = (dm_ce_even == '0) && (dm_ce_odd != '0);
    if (dm_start)
    begin
      if (dm_phase_r == DM_FIRST && dg_req_i[dm_slot_r])
      begin
        dm_dg_nxt = 1'b1;
        dm_bank_nxt = dg_par_i[dm_slot_r];
      end
      else if (dm_phase_r == DM_SECOND && dm_take_r)
      begin
        dm_dg_nxt = 1'b1;
        dm_bank_nxt = !dm_par_r;
      end
      else
      begin
        dm_dg_nxt = 1'b0;
        dm_bank_nxt = dm_use_odd;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      dm_cnt_r <= '0;
      dm_phase_r <= DM_FIRST;
      dm_slot_r <= DM_FIRST_SLOT;
      dm_take_r <= 1'b0;
      dm_par_r <= EVEN_BANK;
      dm_dg_r <= 1'b0;
      dm_bank_r <= EVEN_BANK;
    end
    else
    begin
      dm_cnt_r <= dm_cnt_nxt;
      dm_phase_r <= dm_phase_nxt;
      dm_slot_r <= dm_slot_nxt;
      dm_take_r <= dm_take_nxt;
      dm_par_r <= dm_par_nxt;
      dm_dg_r <= dm_dg_nxt;
      dm_bank_r <= dm_bank_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // display memory: computing element choice per parity

  sa_ce_rotor #(
    .N(NCE)
  ) u_dm_even (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .req_i(dm_ce_even),
    .take_i(dm_ce_cycle && !dm_use_odd),
    .gnt_o(dm_gnt_even)
  );

  sa_ce_rotor #(
    .N(NCE)
  ) u_dm_odd (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .req_i(dm_ce_odd),
    .take_i(dm_ce_cycle && dm_use_odd),
    .gnt_o(dm_gnt_odd)
  );

  always_comb
  begin
    dm_ce_gnt_o = dm_gnt_even | dm_gnt_odd;
    dm_start_o = dm_start;
    dm_dg_o = dm_dg_r;
    dm_bank_o = dm_bank_r;
  end

  ////////////////////////////////////////////////////////////////////
  // display memory checks

  sequence dg_first_s;
    dm_dg_o && !dm_start_o;
  endsequence

  sequence dg_second_s;
    dm_dg_o && (dm_bank_o != $past(dm_bank_o));
  endsequence

  frame_repeat_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (dm_start && dm_phase_r == DM_RESV) |-> ##FRAME_CLKS (dm_start && dm_phase_r == DM_RESV))
    else $error("display frame is not nine cycles long");

  free_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    dm_start |-> ##1 (!dm_start) [*8])
    else $error("display memory cycle shorter than expected");

  slot_owner_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (dg_gnt_o != '0) |-> (dm_phase_r == DM_FIRST && dg_gnt_o == (DM_QW_SLOTS'(1) << dm_slot_r)))
    else $error("display cycle given to a foreign display address");

  quad_pair_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (dg_gnt_o != '0) |-> ##1 dg_first_s ##DM_CYC_CLKS dg_second_s)
    else $error("display quadword not served as a doubleword pair");

  ce_single_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (dm_ce_gnt_o != '0) |-> (dm_start && $onehot(dm_ce_gnt_o) && dg_gnt_o == '0) ##1 !dm_dg_o)
    else $error("computing element display access is not one doubleword");

  idle_slot_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (dm_start && dm_phase_r == DM_FIRST && !dg_req_i[dm_slot_r] && dm_ce_req_i != '0)
      |-> (dm_ce_gnt_o != '0))
    else $error("unused display slot not offered to computing elements");
endmodule
`default_nettype wire

/* sa_pkg.sv */
// constants and types shared by the storage access arbiter
`default_nettype none
package sa_pkg;
  localparam int CLK_NS = 40;
  localparam int SU_CYCLE_NS = 800;
  localparam int IO_HOLD_NS = 750;
  localparam int DM_CYCLE_NS = 800;
  // least times, rounded up to whole clocks
  localparam int SU_CYC_CLKS = (SU_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int IO_HOLD_CLKS = (IO_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DM_CYC_CLKS = (DM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 5;
  localparam int DM_QW_SLOTS = 4;
  localparam int DM_SLOT_W = 2;
  localparam logic [DM_SLOT_W-1:0] DM_FIRST_SLOT = 2'h0;
  localparam logic [DM_SLOT_W-1:0] DM_LAST_SLOT = 2'h3;
  localparam logic EVEN_BANK = 1'b0;
  localparam logic ODD_BANK = 1'b1;
  typedef enum logic [1:0] {
    DM_FIRST = 2'h0,
    DM_SECOND = 2'h1,
    DM_RESV = 2'h3
  } sa_dm_phase_e;
endpackage
`default_nettype wire

/* sa_ce_rotor.sv */
// rotating priority picker among computing element requests
`timescale 1ns/100ps
`default_nettype none
module sa_ce_rotor #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [N-1:0] req_i,
  input wire logic take_i,
  output logic [N-1:0] gnt_o
);
  import sa_pkg::*;
  localparam int IW = (N > 1) ? $clog2(N) : 1;
  localparam logic [IW-1:0] LAST_INIT = IW'(N - 1);
  logic [IW-1:0] last_r;
  logic [IW-1:0] last_nxt;

  function automatic logic [N-1:0] rr_pick(input logic [N-1:0] req, input logic [IW-1:0] last);
    logic [N-1:0] pick;
    logic found;
    int idx;
    pick = '0;
    found = 1'b0;
    for (int k = 1; k <= N; k++)
    begin
      idx = (int'(last) + k) % N;
      if (req[idx] && !found)
      begin
        pick[idx] = 1'b1;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  always_comb
  begin
    gnt_o = take_i ? rr_pick(req_i, last_r) : '0;
    last_nxt = last_r;
    for (int k = 0; k < N; k++)
    begin
      if (gnt_o[k])
      begin
        last_nxt = IW'(k);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      last_r <= LAST_INIT;
    else
      last_r <= last_nxt;
  end

  // a requester just served is passed over while another waits
  rotate_fair_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (take_i && (req_i & ~(N'(1) << last_r)) != '0) |-> (gnt_o & (N'(1) << last_r)) == '0)
    else $error("rotor regranted last winner while others pending");
endmodule
`default_nettype wire

/* sa_store_hold.sv */
// hold-off timers that keep io store requests out of arbitration
`timescale 1ns/100ps
`default_nettype none
module sa_store_hold #(
  parameter int N = 2,
  parameter int HOLD = sa_pkg::IO_HOLD_CLKS
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [N-1:0] req_i,
  input wire logic [N-1:0] store_i,
  output logic [N-1:0] ok_o
);
  import sa_pkg::*;
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD);
  logic [CNT_W-1:0] cnt_r [N];
  logic [CNT_W-1:0] cnt_nxt [N];

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      ok_o[i] = (cnt_r[i] == HOLD_CNT);
      if (!(req_i[i] && store_i[i]))
        cnt_nxt[i] = '0;
      else if (cnt_r[i] == HOLD_CNT)
        cnt_nxt[i] = cnt_r[i];
      else
        cnt_nxt[i] = cnt_r[i] + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!rst_b_i)
        cnt_r[i] <= '0;
      else
        cnt_r[i] <= cnt_nxt[i];
    end
  end
endmodule
`default_nettype wire

/* sa_req_model.sv */
// requester model: raises a request on command, holds it until granted
`timescale 1ns/100ps
`default_nettype none
module sa_req_model #(
  parameter int N = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [N-1:0] raise_i,
  input wire logic [N-1:0] par_in_i,
  input wire logic [N-1:0] st_in_i,
  input wire logic [N-1:0] gnt_i,
  output logic [N-1:0] req_o = '0,
  output logic [N-1:0] par_o = '0,
  output logic [N-1:0] st_o = '0
);
  logic [N-1:0] seen_r;
  ////////////////////////////////////////
  // grant taken at the rising edge
  always_ff @(posedge clk_i)
  begin
    seen_r <= rst_b_i ? (gnt_i & req_o) : '0;
  end
  ////////////////////////////////////////
  // released lines show the inverse of their last value
  always @(negedge clk_i)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!rst_b_i)
        req_o[i] <= 1'b0;
      else if (raise_i[i])
      begin
        req_o[i] <= 1'b1;
        par_o[i] <= par_in_i[i];
        st_o[i] <= st_in_i[i];
      end
      else if (seen_r[i])
      begin
        req_o[i] <= 1'b0;
        par_o[i] <= ~par_o[i];
        st_o[i] <= ~st_o[i];
      end
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the storage access arbiter
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sa_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] cr = '0, cp = '0, cd = '0, cdp = '0;
  logic [1:0] ir = '0, ip = '0, ist = '0;
  logic [3:0] dr = '0, dp = '0;
  logic [2:0] cst = '0;
  logic [3:0] dst = '0;
  logic [2:0] ce_req, ce_par, ce_gnt, dmc_req, dmc_par, dmc_gnt;
  logic [1:0] io_req, io_par, io_st, io_gnt, su_busy;
  logic [3:0] dg_req, dg_par, dg_gnt;
  logic dm_start, dm_dg, dm_bank;
  logic tk = 1'b0;
  int miscompares = 0, num_checks = 0, cyc = 0, nst = 0, pos = 0, lst = 0;
  logic [7:0] gq[$], dq[$];
  int tq[$];
  logic [8:0] dgv = '0, bkv = '0;
  ////////////////////////////////////////
  sa_arbiter u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .su_ce_req_i(ce_req), .su_ce_par_i(ce_par), .su_io_req_i(io_req),
    .su_io_store_i(io_st), .su_io_par_i(io_par), .su_ce_gnt_o(ce_gnt),
    .su_io_gnt_o(io_gnt), .su_busy_o(su_busy), .dm_ce_req_i(dmc_req),
    .dm_ce_par_i(dmc_par), .dg_req_i(dg_req), .dg_par_i(dg_par),
    .dm_ce_gnt_o(dmc_gnt), .dg_gnt_o(dg_gnt), .dm_start_o(dm_start),
    .dm_dg_o(dm_dg), .dm_bank_o(dm_bank)
  );
  sa_req_model #(.N(3)) u_ce (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .raise_i(cr), .par_in_i(cp),
    .st_in_i(cst), .gnt_i(ce_gnt), .req_o(ce_req), .par_o(ce_par), .st_o()
  );
  sa_req_model #(.N(2)) u_io (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .raise_i(ir), .par_in_i(ip),
    .st_in_i(ist), .gnt_i(io_gnt), .req_o(io_req), .par_o(io_par), .st_o(io_st)
  );
  // display side: computing elements and fetch-only generators
  sa_req_model #(.N(3)) u_dmc (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .raise_i(cd), .par_in_i(cdp),
    .st_in_i(cst), .gnt_i(dmc_gnt), .req_o(dmc_req), .par_o(dmc_par), .st_o()
  );
  sa_req_model #(.N(4)) u_dg (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .raise_i(dr), .par_in_i(dp),
    .st_in_i(dst), .gnt_i(dg_gnt), .req_o(dg_req), .par_o(dg_par), .st_o()
  );
  ////////////////////////////////////////
  // grant logger and display frame tracker
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    tk <= 1'b0;
    if (!rst_b_i)
      nst = 0;
    else
    begin
      if (dm_start)
      begin
        if (nst > 0)
          cmp(cyc - lst, DM_CYC_CLKS);
        lst = cyc;
        pos = nst % 9;
        nst++;
        tk <= 1'b1;
      end
      for (int i = 0; i < 4; i++)
      begin
        if (i < 3 && ce_gnt[i])
          gq.push_back(8'(i));
        if (i < 3 && ce_gnt[i])
          tq.push_back(cyc);
        if (i < 2 && io_gnt[i])
          gq.push_back(8'(8 + i));
        if (i < 2 && io_gnt[i])
          tq.push_back(cyc);
        if (i < 3 && dmc_gnt[i])
          dq.push_back(8'(i * 16 + pos));
        if (dg_gnt[i])
          dq.push_back(8'((8 + i) * 16 + pos));
      end
    end
  end
  always @(negedge clk_i)
  begin
    if (tk)
    begin
      dgv[pos] = dm_dg;
      bkv[pos] = dm_bank;
    end
  end
  ////////////////////////////////////////
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // kind 0: su grants, 1: display grants, 2: frame position
  task automatic wait_on(input int kind, input int n);
    int k;
    k = 0;
    while (kind == 2 ? pos != n : (kind == 1 ? dq.size() : gq.size()) < n)
    begin
      @(negedge clk_i);
      k++;
      if (k > 3000)
      begin
        miscompares++;
        give_verdict();
      end
    end
  endtask
  task automatic go(input logic [2:0] c, input logic [1:0] i,
                    input logic [2:0] m, input logic [3:0] d);
    @(negedge clk_i);
    {cr, ir, cd, dr} <= {c, i, m, d};
    @(negedge clk_i);
    {cr, ir, cd, dr} <= '0;
  endtask
  ////////////////////////////////////////
  task automatic t_bank();
    int t0;
    cp = 3'h1;
    go(3'h1, 2'h1, 3'h0, 4'h0);
    wait_on(0, 2);
    cmp(tq[1] - tq[0], 0);
    cmp(su_busy, 2'h3);
    repeat (25) @(negedge clk_i);
    cp = 3'h0;
    gq.delete();
    tq.delete();
    ist = 2'h1;
    go(3'h0, 2'h1, 3'h0, 4'h0);
    t0 = cyc;
    wait_on(0, 1);
    cmp(tq[0] - t0, IO_HOLD_CLKS + 1);
    repeat (25) @(negedge clk_i);
    ist = 2'h0;
  endtask
  task automatic t_order();
    logic [1:0] st [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
    logic [39:0] ex [4] = '{40'h0809000102, 40'h0809000102,
                            40'h0908000102, 40'h0008090102};
    for (int c = 0; c < 4; c++)
    begin
      gq.delete();
      tq.delete();
      ist = st[c];
      go(3'h7, 2'h3, 3'h0, 4'h0);
      wait_on(0, 5);
      for (int j = 0; j < 5; j++)
      begin
        cmp(gq[j], ex[c][39-8*j -: 8]);
        if (j > 0)
          cmp(tq[j] - tq[j-1], SU_CYC_CLKS);
      end
      repeat (25) @(negedge clk_i);
    end
    ist = 2'h0;
  endtask
  task automatic t_rotate();
    gq.delete();
    go(3'h7, 2'h0, 3'h0, 4'h0);
    wait_on(0, 2);
    go(3'h1, 2'h1, 3'h0, 4'h0);
    wait_on(0, 5);
    cmp({gq[0], gq[1], gq[2], gq[3], gq[4]}, 40'h0001080200);
    repeat (25) @(negedge clk_i);
  endtask
  task automatic t_display();
    dq.delete();
    dp = 4'h2;
    wait_on(2, 7);
    wait_on(2, 8);
    go(3'h0, 2'h0, 3'h1, 4'ha);
    wait_on(1, 3);
    cmp({dq[0], dq[1], dq[2]}, 24'h0092b6);
    wait_on(2, 8);
    cmp(dgv[7:0], 8'hcc);
    cmp({bkv[7:6], bkv[3:2], bkv[0]}, 5'h12);
  endtask
  task automatic t_dm_rotate();
    dq.delete();
    cdp = 3'h4;
    wait_on(2, 7);
    wait_on(2, 8);
    go(3'h0, 2'h0, 3'h7, 4'h0);
    wait_on(1, 3);
    cmp({dq[0], dq[1], dq[2]}, 24'h102102);
    cmp(bkv[1:0], 2'h2);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    #1;
    cmp({su_busy, dm_dg, dm_bank, dm_start}, 5'h01);
    t_bank();
    t_order();
    t_rotate();
    t_display();
    t_dm_rotate();
    give_verdict();
  end
endmodule
`default_nettype wire
